//--- hw/cpu_reset_startup_sequencer.v
// Function
// (RULE_01) During reset drive status, ack, address, byte enable, lock high; others low; data floats.
// (RULE_02) Operation begins only after reset falls from high to low.
// (RULE_03) System makes the reset release edge synchronous to the system clock.
// (RULE_04) About 50 cycles of initialisation precede the first code fetch.
// (RULE_05) Synchronous reset rise starts a new processor cycle at next clock edge; the code restarts the phase two edges later, through the synchroniser.
// (RULE_06) Asynchronous reset rise is accepted; processor phase then indeterminate.
// (RULE_07) System asserts reset synchronously when phase lock to another clock matters.
// (RULE_08) System may hold reset up to 5 ms while bias settles.
// (RULE_09) Reset is active high, held over 16 cycles, clears internal logic.
// (RULE_10) Initialisation delay is a counter from release enabling first fetch.
`timescale 1ns/1ps
`include "cpu_reset_defs.vh"
module cpu_reset_startup_sequencer (
    // Clock and local reset
    input wire i_clk,
    input wire i_resetn,
    // Processor reset pin, active high
    input wire i_cpu_reset,
    // Core side: bus values when running, and fetch handshake
    input wire [1:0] i_core_status,
    input wire i_core_ext_ack,
    input wire [23:0] i_core_addr,
    input wire i_core_upper_byte_enable,
    input wire i_core_lock,
    input wire i_core_mem_io,
    input wire i_core_code_or_int_ack,
    input wire i_core_hold_grant,
    input wire [15:0] i_core_data,
    input wire i_core_data_oe,
    input wire i_fetch_done,
    output wire o_fetch_request,
    output wire o_running,
    output reg o_phase,
    output wire o_cycle_start,
    // Bus pins
    output reg o_status_line_zero,
    output reg o_status_line_one,
    output reg o_extension_operand_ack,
    output reg [23:0] o_addr,
    output reg o_upper_byte_enable,
    output reg o_lock,
    output reg o_memory_or_io_select,
    output reg o_code_or_int_ack,
    output reg o_hold_grant,
    output reg [15:0] o_data,
    output reg o_data_oe
);
    localparam ST_RESET = 4'b0001;
    localparam ST_INIT = 4'b0010;
    localparam ST_FETCH = 4'b0100;
    localparam ST_RUN = 4'b1000;

    reg rst_meta;
    reg rst_sync;
    reg rst_prev;
    reg [3:0] state;
    reg [3:0] next_state;
    reg [`INIT_CNT_W-1:0] init_cnt;
    reg [`HOLD_CNT_W-1:0] hold_cnt;
    reg hold_ok;
    wire phase_w;
    wire start_w;
    wire in_reset;
    wire release_edge;
    wire release_ok;
    // Reset pin levels, kept in one place for both quiet states.
    wire [1:0] rst_status;
    wire [23:0] rst_addr;
    wire [15:0] rst_data;

    assign rst_status = `RST_STATUS;
    assign rst_addr = `RST_ADDR;
    assign rst_data = `RST_DATA;

    // The pin may be asynchronous; only the second and third stages are read.
    // Stages reset high so that a local reset looks like a held pin.
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            rst_meta <= 1'b1;
            rst_sync <= 1'b1;
            rst_prev <= 1'b1;
        end else begin
            rst_meta <= i_cpu_reset;
            rst_sync <= rst_meta;
            rst_prev <= rst_sync;
        end
    end

    // Local reset counts as a processor reset and restarts the phase.
    assign in_reset = rst_sync | ~i_resetn;
    // (RULE_02) Release edge detect.
    assign release_edge = rst_prev & ~rst_sync;
    // A release counts only after a hold long enough to clear the core.
    assign release_ok = release_edge & hold_ok;

    // (RULE_09) Hold length check.
    // A pulse of 16 cycles or less is not a valid reset; the sequencer stays in ST_RESET after it.
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            hold_cnt <= {`HOLD_CNT_W{1'b0}};
            hold_ok <= 1'b0;
        end else if (!rst_sync) begin
            hold_cnt <= {`HOLD_CNT_W{1'b0}};
            hold_ok <= 1'b0;
        end else if (hold_cnt < `RESET_HOLD_MIN) begin
            hold_cnt <= hold_cnt + 5'h01;
        end else begin
            hold_ok <= 1'b1;
        end
    end

    // (RULE_05) Phase restart on reset.
    // (RULE_06) Async rise tolerated.
    // The synchroniser adds latency, so phase relative to the pin is fixed
    // only when the pin edge meets setup; otherwise it may slip by one.
    phase_divider u_phase (
        .i_clk(i_clk),
        .i_restart(in_reset),
        .o_phase(phase_w),
        .o_cycle_start(start_w)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_RESET: begin
                // (RULE_02) Start on release.
                if (release_ok) begin
                    next_state = ST_INIT;
                end
            end
            // Exact count for repeatable fetch timing after each release.
            ST_INIT: begin
                // (RULE_04) Wait init cycles.
                if (init_cnt == `INIT_CYCLES - 8'd1) begin
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // (RULE_10) Request stands until taken.
                if (i_fetch_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: next_state = ST_RUN;
            default: next_state = ST_RESET;
        endcase
    end

    // (RULE_09) Reset clears state.
    always @(posedge i_clk) begin
        if (in_reset) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // (RULE_10) Init cycle counter.
    always @(posedge i_clk) begin
        if (state != ST_INIT) begin
            init_cnt <= {`INIT_CNT_W{1'b0}};
        end else begin
            init_cnt <= init_cnt + 8'd1;
        end
    end

    // The divider output is already a flop; a second stage here would put
    // the phase one cycle behind the cycle start strobe.
    always @* begin
        o_phase = phase_w;
    end
    assign o_cycle_start = start_w & (state != ST_RESET);
    // (RULE_10) Fetch enable.
    assign o_fetch_request = (state == ST_FETCH);
    assign o_running = (state == ST_RUN);

    // (RULE_01) Reset pin levels.
    // Core values are passed only once out of reset, so nothing toggles
    // on the bus before the release edge.
    always @(posedge i_clk) begin
        if (in_reset || state == ST_RESET) begin
            o_status_line_zero <= rst_status[0];
            o_status_line_one <= rst_status[1];
            o_extension_operand_ack <= 1'b1;
            o_addr <= rst_addr;
            o_upper_byte_enable <= 1'b1;
            o_lock <= 1'b1;
            o_memory_or_io_select <= 1'b0;
            o_code_or_int_ack <= 1'b0;
            o_hold_grant <= 1'b0;
            o_data <= rst_data;
            o_data_oe <= 1'b0;
        end else if (state == ST_INIT) begin
            // No bus cycle runs before the first fetch, so pins stay quiet.
            o_status_line_zero <= rst_status[0];
            o_status_line_one <= rst_status[1];
            o_extension_operand_ack <= 1'b1;
            o_addr <= rst_addr;
            o_upper_byte_enable <= 1'b1;
            o_lock <= 1'b1;
            o_memory_or_io_select <= 1'b0;
            o_code_or_int_ack <= 1'b0;
            o_hold_grant <= 1'b0;
            o_data <= rst_data;
            o_data_oe <= 1'b0;
        end else begin
            o_status_line_zero <= i_core_status[0];
            o_status_line_one <= i_core_status[1];
            o_extension_operand_ack <= i_core_ext_ack;
            o_addr <= i_core_addr;
            o_upper_byte_enable <= i_core_upper_byte_enable;
            o_lock <= i_core_lock;
            o_memory_or_io_select <= i_core_mem_io;
            o_code_or_int_ack <= i_core_code_or_int_ack;
            o_hold_grant <= i_core_hold_grant;
            o_data <= i_core_data;
            o_data_oe <= i_core_data_oe;
        end
    end
endmodule // cpu_reset_startup_sequencer

//--- hw/cpu_reset_defs.vh
`ifndef CPU_RESET_DEFS_VH
`define CPU_RESET_DEFS_VH
// Internal initialisation time after reset release, in clock cycles.
`define INIT_CYCLES 8'd50
// Least reset hold time in system clock cycles; hold must exceed this.
`define RESET_HOLD_MIN 5'd16
`define INIT_CNT_W 8
`define HOLD_CNT_W 5
// Pin levels while reset is active.
`define RST_STATUS 2'h3
`define RST_ADDR 24'hffffff
`define RST_DATA 16'h0000
`endif

//--- hw/phase_divider.v
`timescale 1ns/1ps
// Two-phase processor clock: one system clock per phase, enable on phase 0.
module phase_divider (
    // Clock and restart
    input wire i_clk,
    input wire i_restart,
    // Phase outputs
    output reg o_phase,
    output wire o_cycle_start
);
    // Restart pins phase 0 so the next cycle is known.
    always @(posedge i_clk) begin
        if (i_restart) begin
            o_phase <= 1'b0;
        end else begin
            o_phase <= ~o_phase;
        end
    end
    assign o_cycle_start = ~o_phase & ~i_restart;
endmodule // phase_divider

//--- tb/cpu_reset_startup_sequencer_properties.sv
`timescale 1ns/1ps
module cpu_reset_startup_sequencer_properties (
    // Clock, reset and handshake
    input wire i_clk, input wire i_resetn, input wire i_cpu_reset,
    input wire i_fetch_done, input wire o_fetch_request,
    input wire o_running, input wire o_phase, input wire o_cycle_start,
    // Bus pins
    input wire o_status_line_zero, input wire o_status_line_one,
    input wire o_extension_operand_ack, input wire [23:0] o_addr,
    input wire o_upper_byte_enable, input wire o_lock,
    input wire o_memory_or_io_select, input wire o_code_or_int_ack,
    input wire o_hold_grant, input wire o_data_oe
);
    // Margins on the hold count absorb the pin synchroniser delay.
    reg [4:0] held;
    always @(posedge i_clk) begin
        if (!i_resetn || !i_cpu_reset)
            held <= 5'h00;
        else if (held != 5'h1f)
            held <= held + 5'h01;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence in_reset; i_cpu_reset [*4]; endsequence
    sequence good_rel; $fell(i_cpu_reset) && held > 5'h12; endsequence
    sequence short_rel;
        $fell(i_cpu_reset) && held != 5'h00 && held < 5'h0e;
    endsequence
    AST_PINS_HIGH: assert property (in_reset |=> o_status_line_zero
        && o_status_line_one && o_extension_operand_ack && o_lock
        && o_addr == 24'hffffff && o_upper_byte_enable) else $error("pins");
    AST_PINS_LOW: assert property (in_reset |=> !o_hold_grant
        && !o_memory_or_io_select && !o_code_or_int_ack) else $error("low");
    AST_FLOAT: assert property (in_reset |=> !o_data_oe)
        else $error("data driven in reset");
    AST_NO_START: assert property (in_reset |=> !o_fetch_request
        && !o_running && !o_cycle_start) else $error("early activity");
    AST_INIT_QUIET: assert property (good_rel |-> ##41
        (!o_fetch_request) [*8]) else $error("fetch too early");
    AST_INIT_LEN: assert property (good_rel |-> ##[50:54]
        o_fetch_request) else $error("fetch late");
    AST_FETCH_STANDS: assert property (o_fetch_request && !i_fetch_done
        && !i_cpu_reset |=> o_fetch_request) else $error("fetch dropped");
    AST_RUN: assert property (o_fetch_request && i_fetch_done |=>
        o_running && !o_fetch_request) else $error("no run");
    AST_SHORT: assert property (short_rel |-> ##4
        (o_addr == 24'hffffff && !o_fetch_request) [*8]) else $error("short");
    AST_PHASE: assert property (o_cycle_start |-> !o_phase)
        else $error("cycle start off phase");
    AST_PHASE_ALT: assert property (o_cycle_start |=> o_phase
        && !o_cycle_start) else $error("phase did not advance");
endmodule // cpu_reset_startup_sequencer_properties

//--- tb/sys_reset_source.sv
`timescale 1ns/1ps
module sys_reset_source #(
    // Short stand-in for the bias settling hold at power-up.
    parameter PWR_HOLD = 5'd30
) (
    // Clock and request
    input wire i_clk,
    input wire i_go,
    input wire [4:0] i_hold,
    // Processor reset pin, active high
    output reg o_cpu_reset = 1'b1
);
    reg [4:0] left = PWR_HOLD;
    always @(posedge i_clk) begin
        if (i_go) begin
            o_cpu_reset <= 1'b1;
            left <= i_hold;
        end else if (left != 5'h00)
            left <= left - 5'h01;
        else
            o_cpu_reset <= 1'b0;
    end
endmodule // sys_reset_source

//--- tb/cpu_reset_startup_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "cpu_reset_defs.vh"
module cpu_reset_startup_sequencer_tb_top;
    reg i_clk = 1'b0;
    reg i_resetn = 1'b0;
    reg go = 1'b0;
    reg done = 1'b0;
    reg [4:0] hold = 5'h00;
    reg [48:0] core = 49'h5a3c_9617_e2d4;
    reg fetch_phase = 1'b0;
    integer starts = 0;
    wire rst, req, run, phase, cyc;
    wire [8:0] p;
    wire [23:0] addr;
    wire [15:0] data;
    integer fails = 0;
    integer checks = 0;
    integer n;
    always #25 i_clk = ~i_clk;
    sys_reset_source u_sys_reset_source (.i_clk(i_clk), .i_go(go),
        .i_hold(hold), .o_cpu_reset(rst));
    cpu_reset_startup_sequencer u_cpu_reset_startup_sequencer (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_cpu_reset(rst),
        .i_core_status(core[1:0]), .i_core_ext_ack(core[2]),
        .i_core_addr(core[26:3]), .i_core_upper_byte_enable(core[27]),
        .i_core_lock(core[28]), .i_core_mem_io(core[29]),
        .i_core_code_or_int_ack(core[30]), .i_core_hold_grant(core[31]),
        .i_core_data(core[47:32]), .i_core_data_oe(core[48]),
        .i_fetch_done(done), .o_fetch_request(req), .o_running(run),
        .o_phase(phase), .o_cycle_start(cyc), .o_status_line_zero(p[0]),
        .o_status_line_one(p[1]), .o_extension_operand_ack(p[2]),
        .o_addr(addr), .o_upper_byte_enable(p[3]), .o_lock(p[4]),
        .o_memory_or_io_select(p[5]), .o_code_or_int_ack(p[6]),
        .o_hold_grant(p[7]), .o_data(data), .o_data_oe(p[8]));
    task check(input [63:0] seen, input [63:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("fails %0d checks %0d", fails, checks);
            if (fails == 0 && checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task bound(input integer lim);
        begin
            if (n >= lim) begin
                fails = fails + 1;
                stop_test;
            end
        end
    endtask
    task t_levels;
        begin
            @(negedge i_clk);
            check({p, addr, req}, {9'h01f, `RST_ADDR, 1'b0});
            check(phase, 1'b0);
            check(cyc, 1'b0);
        end
    endtask
    task t_startup;
        begin
            for (n = 0; rst !== 1'b1 && n < 60; n = n + 1)
                @(negedge i_clk);
            bound(60);
            for (n = 0; rst !== 1'b0 && n < 60; n = n + 1)
                @(negedge i_clk);
            bound(60);
            for (n = 0; req !== 1'b1 && n < 99; n = n + 1)
                @(negedge i_clk);
            bound(99);
            check(n >= `INIT_CYCLES && n <= `INIT_CYCLES + 4, 1);
            check(cyc, !phase);
            if (starts > 0)
                check(phase, fetch_phase);
            fetch_phase = phase;
            starts = starts + 1;
            @(posedge i_clk) begin
                done <= 1'b1;
                core <= ~core;
            end
            @(posedge i_clk) done <= 1'b0;
            @(negedge i_clk);
            check({run, req}, 2'b10);
            check({p, addr, data}, {core[48], core[31:27], core[2:0],
                core[26:3], core[47:32]});
        end
    endtask
    task pulse(input [4:0] len);
        begin
            @(posedge i_clk) begin
                go <= 1'b1;
                hold <= len;
            end
            @(posedge i_clk) go <= 1'b0;
        end
    endtask
    task t_short;
        begin
            pulse(5'h04);
            repeat (80) @(negedge i_clk);
            check({p, addr, req}, {9'h01f, `RST_ADDR, 1'b0});
            check(run, 1'b0);
        end
    endtask
    task t_restart;
        begin
            pulse(5'h14);
            t_startup;
        end
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_levels;
        t_startup;
        t_short;
        t_restart;
        stop_test;
    end
endmodule // cpu_reset_startup_sequencer_tb_top
bind cpu_reset_startup_sequencer cpu_reset_startup_sequencer_properties
    u_props (.*);
